// ### rtl/eps_sideband_ctrl.sv
// Sideband control and status logic of the MAC and PCS, with APB registers
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`include "eps_map.svh"
`default_nettype none

// What this block does
// - Tolerance input acts only with insertion off
// - Tolerance high counts bad-FCS packet good
// - Bad FCS flags status and raises stomped FCS
// - Tolerated packet raises both good and bad-FCS statistics strobes, counts only as good
// - Markers every interval plus one words
// - Each lane inserts its own marker value
// - Local fault level while encoder initializes
// - Custom preamble replaces standard when enabled
// - Rate select: 0 is 50G, 1 is 40G
// - Receive disable finishes packet, stops decoding
// - Disabled receive: no statistics, stream idle
// - Check preamble when enabled
// - Check start delimiter when enabled
// - Forced resync resets and realigns receive path
// - FCS removal strips FCS, setting changed in reset
// - Keep FCS on packets of eight bytes or less
// - Insertion appends FCS, changed only between packets
module eps_sideband_ctrl #(
    parameter int LANE_COUNT = 4
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Transmit packet events
    input  wire logic                    tx_sop,
    input  wire logic                    tx_pkt_end,
    input  wire logic                    tx_pkt_fcs_bad,
    input  wire logic [55:0]             tx_preamblein,
    input  wire logic                    tx_word_strobe,
    input  wire logic [LANE_COUNT*64-1:0] tx_lane_marker_value,
    input  wire logic                    tx_link_ready_pin,
    // Transmit controls and status
    output logic                         tx_fcs_append,
    output logic      [55:0]             tx_preamble_out,
    output logic                         tx_stat_good,
    output logic                         tx_stat_bad_fcs,
    output logic                         tx_stomped_fcs,
    output logic                         tx_local_fault,
    output logic                         tx_marker_insert,
    output logic      [LANE_COUNT*64-1:0] tx_marker_out,
    output logic                         rate_40g,
    // Receive packet events
    input  wire logic                    rx_sop,
    input  wire logic                    rx_pre_ok,
    input  wire logic                    rx_sfd_ok,
    input  wire logic                    rx_eop,
    input  wire logic [13:0]             rx_len,
    input  wire logic                    rx_fcs_bad,
    // Receive controls and status
    output logic                         rx_decode_en,
    output logic                         rx_eop_err,
    output logic                         rx_strip_fcs,
    output logic                         rx_stat_pkt,
    output logic                         rx_resync
);

    if (LANE_COUNT < 1 || LANE_COUNT > 32)
    begin : g_check
        $error("LANE_COUNT must be 1 to 32");
    end

    typedef struct packed {
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic [`EPS_CTRL_W-1:0]      ctrl;
        logic [15:0]                 mark_ivl;
        logic                        rx_del;
        logic                        tx_bad_seen;
        logic [31:0]                 tx_good_cnt;
        logic [31:0]                 tx_bad_cnt;
        logic [31:0]                 rx_good_cnt;
        logic [31:0]                 rx_err_cnt;
        logic [2:0]                  link_sync;
        logic                        link_ok;
        eps_pkg::eps_tx_state_t      txs;
        logic                        tx_in_pkt;
        logic                        fcs_ins;
        logic [55:0]                 preamble;
        logic                        tx_good;
        logic                        tx_bad;
        logic                        tx_stomp;
        logic                        tx_lf;
        logic [15:0]                 word_cnt;
        logic                        mark_ins;
        logic [LANE_COUNT*64-1:0]    mark_out;
        eps_pkg::eps_rx_state_t      rxs;
        logic                        frame_err;
        logic                        rx_err;
        logic                        rx_strip;
        logic                        rx_stat;
        logic                        resync;
        logic                        rx_dec;
    } eps_state_t;

    eps_state_t s_reg;
    eps_state_t s_next;

    function automatic logic [31:0] read_word(input eps_state_t s, input logic [11:0] a);
        unique case (a)
            `EPS_CTRL_OFS:    read_word = {22'h000000, s.ctrl};
            `EPS_MARK_OFS:    read_word = {16'h0000, s.mark_ivl};
            `EPS_STATUS_OFS:  read_word = {28'h0000000, s.rxs == eps_pkg::EPS_RX_PKT,
                                           s.tx_bad_seen, s.rxs != eps_pkg::EPS_RX_OFF, s.tx_lf};
            `EPS_TX_GOOD_OFS: read_word = s.tx_good_cnt;
            `EPS_TX_BAD_OFS:  read_word = s.tx_bad_cnt;
            `EPS_RX_GOOD_OFS: read_word = s.rx_good_cnt;
            `EPS_RX_ERR_OFS:  read_word = s.rx_err_cnt;
            default:          read_word = 32'h00000000;
        endcase
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[11:5] == 7'h00) && (a[1:0] == 2'b00);
    endfunction

    always_comb
    begin
        logic acc;
        logic wr;
        logic pkt_bad;
        logic ign_eff;
        acc = 1'b0;
        wr = 1'b0;
        pkt_bad = 1'b0;
        ign_eff = 1'b0;
        s_next = s_reg;

        // APB: one wait cycle, then the answer
        acc = psel && penable && !s_reg.pready;
        wr = acc && pwrite && mapped(paddr);
        s_next.pready = acc;
        s_next.pslverr = acc && !mapped(paddr);
        s_next.prdata = (acc && !pwrite) ? read_word(s_reg, paddr) : 32'h00000000;
        s_next.resync = 1'b0;
        if (wr && paddr == `EPS_CTRL_OFS)
        begin
            s_next.ctrl = pwdata[`EPS_CTRL_W-1:0];
        end
        if (wr && paddr == `EPS_MARK_OFS && s_reg.ctrl[`EPS_CTRL_TX_RST])
        begin
            s_next.mark_ivl = pwdata[15:0];
        end
        if (wr && paddr == `EPS_RESYNC_OFS && pwdata[0])
        begin
            s_next.resync = 1'b1;
        end
        if (wr && paddr == `EPS_STATUS_OFS && pwdata[`EPS_ST_TX_BAD])
        begin
            s_next.tx_bad_seen = 1'b0;
        end
        // Removal setting follows software only while the receive path is held
        if (s_reg.ctrl[`EPS_CTRL_RX_RST])
        begin
            s_next.rx_del = s_reg.ctrl[`EPS_CTRL_RX_DEL];
        end

        // Link ready pin: three stages, accepted once stages two and three agree
        s_next.link_sync = {s_reg.link_sync[1:0], tx_link_ready_pin};
        if (s_reg.link_sync[1] == s_reg.link_sync[2])
        begin
            s_next.link_ok = s_reg.link_sync[2];
        end

        // Transmit encoder
        if (s_reg.ctrl[`EPS_CTRL_TX_RST] || !s_reg.link_ok)
        begin
            s_next.txs = eps_pkg::EPS_TX_INIT;
        end
        else
        begin
            s_next.txs = eps_pkg::EPS_TX_RUN;
        end
        s_next.tx_lf = (s_next.txs == eps_pkg::EPS_TX_INIT);

        // Insertion setting only moves between packets
        if (!s_reg.tx_in_pkt && !tx_sop)
        begin
            s_next.fcs_ins = s_reg.ctrl[`EPS_CTRL_TX_INS];
        end
        if (tx_sop)
        begin
            s_next.tx_in_pkt = 1'b1;
            s_next.preamble = s_reg.ctrl[`EPS_CTRL_TX_PRE] ? tx_preamblein
                                                         : `EPS_STD_PREAMBLE;
        end
        if (tx_pkt_end)
        begin
            s_next.tx_in_pkt = 1'b0;
        end

        // Packet ending: bad FCS is only possible when nothing is appended
        pkt_bad = tx_pkt_end && tx_pkt_fcs_bad && !s_reg.fcs_ins;
        ign_eff = s_reg.ctrl[`EPS_CTRL_TX_IGN] && !s_reg.fcs_ins;
        s_next.tx_bad = pkt_bad;
        s_next.tx_stomp = pkt_bad;
        s_next.tx_good = tx_pkt_end && (!pkt_bad || ign_eff);
        if (tx_pkt_end && (!pkt_bad || ign_eff))
        begin
            s_next.tx_good_cnt = s_reg.tx_good_cnt + 32'h00000001;
        end
        if (pkt_bad && !ign_eff)
        begin
            s_next.tx_bad_cnt = s_reg.tx_bad_cnt + 32'h00000001;
        end
        if (pkt_bad)
        begin
            s_next.tx_bad_seen = 1'b1;
        end

        // Lane markers after every interval plus one words
        s_next.mark_ins = 1'b0;
        if (s_reg.txs == eps_pkg::EPS_TX_INIT)
        begin
            s_next.word_cnt = 16'h0000;
        end
        else if (tx_word_strobe)
        begin
            if (s_reg.word_cnt == s_reg.mark_ivl)
            begin
                s_next.word_cnt = 16'h0000;
                s_next.mark_ins = 1'b1;
                s_next.mark_out = tx_lane_marker_value;
            end
            else
            begin
                s_next.word_cnt = s_reg.word_cnt + 16'h0001;
            end
        end

        // Receive path
        s_next.rx_err = 1'b0;
        s_next.rx_strip = 1'b0;
        s_next.rx_stat = 1'b0;
        unique case (s_reg.rxs)
            eps_pkg::EPS_RX_OFF:
            begin
                if (s_reg.ctrl[`EPS_CTRL_RX_EN])
                begin
                    s_next.rxs = eps_pkg::EPS_RX_IDLE;
                end
            end
            eps_pkg::EPS_RX_IDLE:
            begin
                if (!s_reg.ctrl[`EPS_CTRL_RX_EN])
                begin
                    s_next.rxs = eps_pkg::EPS_RX_OFF;
                end
                else if (rx_sop)
                begin
                    s_next.rxs = eps_pkg::EPS_RX_PKT;
                    s_next.frame_err = (s_reg.ctrl[`EPS_CTRL_CHK_PRE] && !rx_pre_ok)
                                    || (s_reg.ctrl[`EPS_CTRL_CHK_SFD] && !rx_sfd_ok);
                end
            end
            eps_pkg::EPS_RX_PKT:
            begin
                if (rx_eop)
                begin
                    // A packet in flight completes even after disable
                    s_next.rxs = s_reg.ctrl[`EPS_CTRL_RX_EN] ? eps_pkg::EPS_RX_IDLE
                                                           : eps_pkg::EPS_RX_OFF;
                    s_next.rx_err = s_reg.frame_err || rx_fcs_bad;
                    s_next.rx_strip = s_reg.rx_del && (rx_len > `EPS_FCS_KEEP_LEN);
                    s_next.rx_stat = 1'b1;
                    if (s_reg.frame_err || rx_fcs_bad)
                    begin
                        s_next.rx_err_cnt = s_reg.rx_err_cnt + 32'h00000001;
                    end
                    else
                    begin
                        s_next.rx_good_cnt = s_reg.rx_good_cnt + 32'h00000001;
                    end
                end
            end
            default:
            begin
                s_next.rxs = eps_pkg::EPS_RX_OFF;
            end
        endcase
        if (s_reg.resync || s_reg.ctrl[`EPS_CTRL_RX_RST])
        begin
            s_next.rxs = eps_pkg::EPS_RX_OFF;
            s_next.rx_err = 1'b0;
            s_next.rx_strip = 1'b0;
            s_next.rx_stat = 1'b0;
        end
        // Decode enable follows the next state so the stream stays idle while off
        s_next.rx_dec = (s_next.rxs != eps_pkg::EPS_RX_OFF);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.ctrl <= `EPS_CTRL_RST;
            s_reg.mark_ivl <= `EPS_MARK_RST;
            s_reg.fcs_ins <= 1'b1;
            s_reg.tx_lf <= 1'b1;
            s_reg.txs <= eps_pkg::EPS_TX_INIT;
            s_reg.rxs <= eps_pkg::EPS_RX_OFF;
            s_reg.preamble <= `EPS_STD_PREAMBLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign prdata           = s_reg.prdata;
    assign pready           = s_reg.pready;
    assign pslverr          = s_reg.pslverr;
    assign tx_fcs_append    = s_reg.fcs_ins;
    assign tx_preamble_out  = s_reg.preamble;
    assign tx_stat_good     = s_reg.tx_good;
    assign tx_stat_bad_fcs  = s_reg.tx_bad;
    assign tx_stomped_fcs   = s_reg.tx_stomp;
    assign tx_local_fault   = s_reg.tx_lf;
    assign tx_marker_insert = s_reg.mark_ins;
    assign tx_marker_out    = s_reg.mark_out;
    assign rate_40g         = s_reg.ctrl[`EPS_CTRL_RATE40];
    assign rx_eop_err       = s_reg.rx_err;
    assign rx_strip_fcs     = s_reg.rx_strip;
    assign rx_stat_pkt      = s_reg.rx_stat;
    assign rx_resync        = s_reg.resync;
    assign rx_decode_en     = s_reg.rx_dec;

endmodule // eps_sideband_ctrl
`default_nettype wire

// ### rtl/eps_map.svh
// Register offsets, field positions, reset values and counts of the sideband controller
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH

`define EPS_CTRL_OFS       12'h000
`define EPS_RESYNC_OFS     12'h004
`define EPS_MARK_OFS       12'h008
`define EPS_STATUS_OFS     12'h00c
`define EPS_TX_GOOD_OFS    12'h010
`define EPS_TX_BAD_OFS     12'h014
`define EPS_RX_GOOD_OFS    12'h018
`define EPS_RX_ERR_OFS     12'h01c

`define EPS_CTRL_TX_INS    0
`define EPS_CTRL_TX_IGN    1
`define EPS_CTRL_TX_PRE    2
`define EPS_CTRL_RATE40    3
`define EPS_CTRL_RX_EN     4
`define EPS_CTRL_CHK_PRE   5
`define EPS_CTRL_CHK_SFD   6
`define EPS_CTRL_RX_DEL    7
`define EPS_CTRL_TX_RST    8
`define EPS_CTRL_RX_RST    9
`define EPS_CTRL_W         10
`define EPS_CTRL_RST       10'h311

`define EPS_ST_TX_LF       0
`define EPS_ST_RX_DEC      1
`define EPS_ST_TX_BAD      2
`define EPS_ST_RX_PKT      3

`define EPS_MARK_RST       16'h3fff
`define EPS_STD_PREAMBLE   56'h55555555555555
`define EPS_FCS_KEEP_LEN   14'h0008

`endif

// ### rtl/eps_pkg.sv
// Types shared by the sideband controller
`default_nettype none
package eps_pkg;
    typedef enum logic [0:0] {
        EPS_TX_INIT = 1'b0,
        EPS_TX_RUN  = 1'b1
    } eps_tx_state_t;

    typedef enum logic [1:0] {
        EPS_RX_OFF  = 2'b00,
        EPS_RX_IDLE = 2'b01,
        EPS_RX_PKT  = 2'b10
    } eps_rx_state_t;
endpackage
`default_nettype wire

// ### bench/eps_sideband_monitor.sv
// Assertion checker on the sideband controller ports
`default_nettype none
module eps_sideband_monitor #(
    parameter int LANE_COUNT = 4
) (
    // Clock and reset
    input wire logic                     sys_clk,
    input wire logic                     rst,
    // APB
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pready,
    // Transmit
    input wire logic                     tx_pkt_end,
    input wire logic                     tx_pkt_fcs_bad,
    input wire logic                     tx_fcs_append,
    input wire logic                     tx_stat_good,
    input wire logic                     tx_stat_bad_fcs,
    input wire logic                     tx_stomped_fcs,
    input wire logic                     tx_local_fault,
    input wire logic                     tx_word_strobe,
    input wire logic                     tx_marker_insert,
    input wire logic [LANE_COUNT*64-1:0] tx_lane_marker_value,
    input wire logic [LANE_COUNT*64-1:0] tx_marker_out,
    // Receive
    input wire logic                     rx_eop,
    input wire logic [13:0]              rx_len,
    input wire logic                     rx_decode_en,
    input wire logic                     rx_strip_fcs,
    input wire logic                     rx_stat_pkt,
    input wire logic                     rx_resync
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("pready not after one wait cycle");
    a_tx_ins_ignores: assert property (tx_pkt_end && tx_fcs_append |=> tx_stat_good && !tx_stat_bad_fcs)
        else $error("bad fcs not ignored under insertion");
    a_tx_bad_flags: assert property (tx_pkt_end && tx_pkt_fcs_bad && !tx_fcs_append |=> tx_stat_bad_fcs && tx_stomped_fcs)
        else $error("bad fcs not flagged");
    a_lf_after_reset: assert property ($fell(rst) |-> tx_local_fault)
        else $error("local fault low after reset");
    a_marker_after_strobe: assert property (tx_marker_insert |-> $past(tx_word_strobe))
        else $error("marker without counted word");
    a_marker_copy: assert property (tx_marker_insert |-> tx_marker_out == tx_lane_marker_value)
        else $error("marker value differs");
    a_strip_len: assert property (rx_strip_fcs |-> $past(rx_eop) && $past(rx_len) > 14'h0008)
        else $error("fcs stripped on short packet");
    a_resync_stops: assert property (rx_resync |-> ##[0:2] !rx_decode_en)
        else $error("resync did not stop decoding");
    a_rx_off_quiet: assert property (!rx_decode_en && !$past(rx_decode_en) |-> !rx_stat_pkt)
        else $error("statistics while receive off");
endmodule // eps_sideband_monitor
`default_nettype wire

// ### bench/eps_link_partner.sv
// Link partner model: lane readiness, word pacing and receive frames
`default_nettype none
module eps_link_partner (
    // Clock
    input  wire logic        sys_clk,
    // Toward the controller
    output var logic         link_ready,
    output var logic         word_strobe,
    output var logic         rx_sop,
    output var logic         rx_pre_ok,
    output var logic         rx_sfd_ok,
    output var logic         rx_eop,
    output var logic [13:0]  rx_len
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        link_ready = 1'b0;
        word_strobe = 1'b0;
        rx_sop = 1'b0;
        rx_pre_ok = 1'b0;
        rx_sfd_ok = 1'b0;
        rx_eop = 1'b0;
        rx_len = 14'h0000;
    end
    task automatic link_up();
        @(posedge sys_clk);
        link_ready <= 1'b1;
    endtask
    task automatic words(input int n);
        repeat (n) @(posedge sys_clk) word_strobe <= 1'b1;
        @(posedge sys_clk);
        word_strobe <= 1'b0;
        #1;
    endtask
    // Check qualifiers are only meaningful with the start; inverted afterwards
    task automatic frame(input logic [13:0] len, input logic [1:0] ok, input int gap);
        @(posedge sys_clk);
        rx_sop <= 1'b1;
        rx_pre_ok <= ok[0];
        rx_sfd_ok <= ok[1];
        @(posedge sys_clk);
        rx_sop <= 1'b0;
        rx_pre_ok <= ~ok[0];
        rx_sfd_ok <= ~ok[1];
        repeat (gap) @(posedge sys_clk);
        rx_eop <= 1'b1;
        rx_len <= len;
        @(posedge sys_clk);
        rx_eop <= 1'b0;
        rx_len <= ~len;
        #1;
    endtask
endmodule // eps_link_partner
`default_nettype wire

// ### bench/eps_sideband_ctrl_tb.sv
// Self-checking bench of the sideband controller
`include "eps_map.svh"
`default_nettype none
module eps_sideband_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LANE_COUNT = 2;
    localparam logic [55:0] CUSTOM = 56'h0d5a5a5a5a5a5a;
    localparam logic [31:0] CTL [3] = '{32'h211, 32'h216, 32'h208};
    localparam logic [13:0] LEN [4] = '{14'h0040, 14'h0008, 14'h0040, 14'h0009};
    logic         sys_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         tx_sop, tx_pkt_end, tx_pkt_fcs_bad, tx_word_strobe, tx_link_ready_pin, tx_fcs_append;
    logic [55:0]  tx_preamblein, tx_preamble_out;
    logic         tx_stat_good, tx_stat_bad_fcs, tx_stomped_fcs, tx_local_fault, tx_marker_insert, rate_40g;
    logic [127:0] marks, tx_marker_out;
    logic         rx_sop, rx_pre_ok, rx_sfd_ok, rx_eop, rx_fcs_bad, rx_decode_en;
    logic         rx_eop_err, rx_strip_fcs, rx_stat_pkt, rx_resync;
    logic [13:0]  rx_len;
    int           err_count, comparisons, i;

    eps_sideband_ctrl #(.LANE_COUNT(LANE_COUNT)) i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_sop(tx_sop), .tx_pkt_end(tx_pkt_end), .tx_pkt_fcs_bad(tx_pkt_fcs_bad),
        .tx_preamblein(tx_preamblein), .tx_word_strobe(tx_word_strobe), .tx_lane_marker_value(marks),
        .tx_link_ready_pin(tx_link_ready_pin), .tx_fcs_append(tx_fcs_append), .tx_preamble_out(tx_preamble_out),
        .tx_stat_good(tx_stat_good), .tx_stat_bad_fcs(tx_stat_bad_fcs), .tx_stomped_fcs(tx_stomped_fcs),
        .tx_local_fault(tx_local_fault), .tx_marker_insert(tx_marker_insert), .tx_marker_out(tx_marker_out),
        .rate_40g(rate_40g), .rx_sop(rx_sop), .rx_pre_ok(rx_pre_ok), .rx_sfd_ok(rx_sfd_ok), .rx_eop(rx_eop),
        .rx_len(rx_len), .rx_fcs_bad(rx_fcs_bad), .rx_decode_en(rx_decode_en), .rx_eop_err(rx_eop_err),
        .rx_strip_fcs(rx_strip_fcs), .rx_stat_pkt(rx_stat_pkt), .rx_resync(rx_resync));
    eps_link_partner i_link (.sys_clk(sys_clk), .link_ready(tx_link_ready_pin), .word_strobe(tx_word_strobe),
        .rx_sop(rx_sop), .rx_pre_ok(rx_pre_ok), .rx_sfd_ok(rx_sfd_ok), .rx_eop(rx_eop), .rx_len(rx_len));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp, input string name);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input int w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w[0];
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        // Sample at the edge itself, before the slave's registers move on
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        if (pready !== 1'b1)
        begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic wait_for(input int sel);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 200 && !hit; n++)
        begin
            @(posedge sys_clk);
            #1;
            hit = sel == 0 ? tx_local_fault === 1'b0 : sel == 1 ? rx_decode_en === 1'b1 : rx_decode_en === 1'b0;
        end
        if (!hit)
        begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic tx_pulse(input logic is_end, input logic bad);
        @(posedge sys_clk);
        tx_sop <= ~is_end;
        tx_pkt_end <= is_end;
        tx_pkt_fcs_bad <= bad;
        tx_preamblein <= CUSTOM;
        @(posedge sys_clk);
        tx_sop <= 1'b0;
        tx_pkt_end <= 1'b0;
        tx_pkt_fcs_bad <= ~bad;
        tx_preamblein <= ~CUSTOM;
        #1;
    endtask

    initial
    begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_sop, tx_pkt_end, tx_pkt_fcs_bad, tx_preamblein, rx_fcs_bad} = '0;
        marks = 128'h0123456789abcdef_fedcba9876543210;
        err_count = 0;
        comparisons = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        apb(0, `EPS_CTRL_OFS, 0);
        chk(rd, 32'h311, "ctrl reset");
        apb(0, `EPS_STATUS_OFS, 0);
        chk(rd, 32'h1, "status reset");
        chk(rate_40g, 1'b0, "rate reset");
        apb(1, 12'h020, 32'h5);
        chk(err, 1'b1, "unmapped error");
        apb(1, `EPS_MARK_OFS, 1);
        apb(1, `EPS_CTRL_OFS, 32'h211);
        i_link.link_up();
        wait_for(0);
        chk(tx_local_fault, 1'b0, "fault cleared");
        i_link.words(2);
        chk(tx_marker_insert, 1'b1, "marker insert");
        chk(tx_marker_out, marks, "marker value");
        apb(1, `EPS_MARK_OFS, 7);
        apb(0, `EPS_MARK_OFS, 0);
        chk(rd, 32'h1, "interval locked");
        $display("test markers done");
        for (i = 0; i < 3; i++)
        begin
            apb(1, `EPS_CTRL_OFS, CTL[i]);
            tx_pulse(1'b0, 1'b0);
            chk(tx_preamble_out, i == 1 ? CUSTOM : `EPS_STD_PREAMBLE, "preamble");
            chk(rate_40g, i == 2, "rate");
            chk(tx_fcs_append, i == 0, "fcs append");
            tx_pulse(1'b1, 1'b1);
            chk(tx_stat_good, i < 2, "stat good");
            chk({tx_stat_bad_fcs, tx_stomped_fcs}, {2{i > 0}}, "bad flags");
        end
        apb(0, `EPS_TX_GOOD_OFS, 0);
        chk(rd, 32'h2, "good count");
        apb(0, `EPS_TX_BAD_OFS, 0);
        chk(rd, 32'h1, "bad count");
        apb(0, `EPS_STATUS_OFS, 0);
        chk(rd, 32'h4, "status bad seen");
        $display("test transmit done");
        apb(1, `EPS_CTRL_OFS, 32'h2f0);
        apb(1, `EPS_CTRL_OFS, 32'h0f0);
        wait_for(1);
        for (i = 0; i < 4; i++)
        begin
            i_link.frame(LEN[i], i == 2 ? 2'b10 : i == 3 ? 2'b01 : 2'b11, 2);
            chk(rx_stat_pkt, 1'b1, "rx stat");
            chk(rx_strip_fcs, i != 1, "strip");
            chk(rx_eop_err, i > 1, "eop error");
        end
        fork
            i_link.frame(14'h0040, 2'b11, 8);
            apb(1, `EPS_CTRL_OFS, 32'h0e0);
        join
        chk(rx_stat_pkt, 1'b1, "finish packet");
        wait_for(2);
        i_link.frame(14'h0040, 2'b11, 0);
        chk(rx_stat_pkt, 1'b0, "no stat off");
        apb(0, `EPS_RX_ERR_OFS, 0);
        chk(rd, 32'h2, "rx error count");
        $display("test receive done");
        apb(1, `EPS_CTRL_OFS, 32'h0f0);
        wait_for(1);
        apb(1, `EPS_RESYNC_OFS, 1);
        chk(rx_resync, 1'b1, "resync pulse");
        @(posedge sys_clk);
        chk(rx_decode_en, 1'b0, "resync stop");
        $display("test resync done");
        stop_test();
    end
endmodule // eps_sideband_ctrl_tb

bind eps_sideband_ctrl eps_sideband_monitor #(.LANE_COUNT(LANE_COUNT)) i_mon (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pready(pready), .tx_pkt_end(tx_pkt_end), .tx_pkt_fcs_bad(tx_pkt_fcs_bad),
    .tx_fcs_append(tx_fcs_append), .tx_stat_good(tx_stat_good), .tx_stat_bad_fcs(tx_stat_bad_fcs),
    .tx_stomped_fcs(tx_stomped_fcs), .tx_local_fault(tx_local_fault), .tx_word_strobe(tx_word_strobe),
    .tx_marker_insert(tx_marker_insert), .tx_lane_marker_value(tx_lane_marker_value),
    .tx_marker_out(tx_marker_out), .rx_eop(rx_eop), .rx_len(rx_len), .rx_decode_en(rx_decode_en),
    .rx_strip_fcs(rx_strip_fcs), .rx_stat_pkt(rx_stat_pkt), .rx_resync(rx_resync));
`default_nettype wire
